// [pts_pkg.sv]
`default_nettype none
package pts_pkg;

  // Register offsets on the plain register port (byte addresses).
  localparam logic [7:0] PTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PTS_STAT_OFS = 8'h04;
  localparam logic [7:0] PTS_CNT_OFS  = 8'h08;

  // Control register fields and reset value.
  localparam int          CTRL_EN_BIT   = 0;  // Program trace enable.
  localparam int          CTRL_HIST_BIT = 1;  // History mode for direct branches.
  localparam int          CTRL_EVTI_BIT = 2;  // Event-in pin may force sync.
  localparam int          CTRL_MARK_BIT = 3;  // Trace-mark filtering enable.
  localparam int          CTRL_SRC_LSB  = 4;  // Four-bit source processor id.
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // Message type codes.
  localparam logic [5:0] TC_DIRECT      = 6'h03;
  localparam logic [5:0] TC_INDIRECT    = 6'h04;
  localparam logic [5:0] TC_ERROR       = 6'h08;
  localparam logic [5:0] TC_DIRECT_SYNC = 6'h0b;
  localparam logic [5:0] TC_INDIR_SYNC  = 6'h0c;
  localparam logic [5:0] TC_RES_FULL    = 6'h1b;
  localparam logic [5:0] TC_HIST        = 6'h1c;
  localparam logic [5:0] TC_HIST_SYNC   = 6'h1d;
  localparam logic [5:0] TC_CORR        = 6'h21;

  // Correlation event codes, resource codes and error codes.
  localparam logic [3:0] EV_TLB_WRITE = 4'hb;
  localparam logic [3:0] EV_TLB_INVAL = 4'hc;
  localparam logic [3:0] EV_PID       = 4'hd;
  localparam logic [3:0] EV_ISPACE    = 4'he;
  localparam logic [3:0] RC_SEQUENTIAL_INSTR_COUNT      = 4'h0;
  localparam logic [3:0] RC_HIST      = 4'h1;
  localparam logic [3:0] ERR_OVERRUN  = 4'h0;
  localparam logic [3:0] ERR_COLLIDE  = 4'h1;
  localparam logic [7:0] RDATA_SEQUENTIAL_INSTR_COUNT   = 8'hff;

  // Counter limits and history reset value (stop bit only).
  localparam logic [7:0]  SEQUENTIAL_INSTR_COUNT_MAX   = 8'hff;
  localparam logic [7:0]  PERIOD_MAX = 8'hff;
  localparam logic [31:0] HIST_RESET = 32'h0000_0001;
  localparam logic [1:0]  PRIO_FULL  = 2'h3;

  // Pending synchronisation flags; the reset flag starts set.
  localparam int          PEND_W     = 10;
  localparam int          P_RESET    = 0;
  localparam int          P_LOWPWR   = 1;
  localparam int          P_DEBUG    = 2;
  localparam int          P_OVERRUN  = 3;
  localparam int          P_PERIODIC = 4;
  localparam int          P_EVTI     = 5;
  localparam int          P_SEQUENTIAL_INSTR_COUNT     = 6;
  localparam int          P_COLLIDE  = 7;
  localparam int          P_VLE      = 8;
  localparam int          P_MARK     = 9;
  localparam logic [9:0]  PEND_RESET = 10'h001;

  // Dropped-type mask bits carried by an overrun error message.
  localparam int DROP_BRANCH = 0;
  localparam int DROP_CORR   = 1;
  localparam int DROP_RES    = 2;
  localparam int DROP_ERR    = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TLB2 = 2'b01,
    ST_DROP = 2'b11
  } pts_state_e;

  typedef enum logic [3:0] {
    K_NONE, K_TLB_HIST, K_TLB_ENTRY, K_INVAL, K_PID, K_ISPACE,
    K_BRANCH, K_RES_SEQUENTIAL_INSTR_COUNT, K_RES_HIST, K_ERR_COLL, K_ERR_OVR
  } pts_kind_e;

  // One retired instruction as reported by the core.
  typedef struct packed {
    logic        valid;
    logic        younger;
    logic        branch;
    logic        indirect;
    logic        taken;
    logic        tlb_write;
    logic        tlb_inval;
    logic        pid_write;
    logic        msr_write;
    logic        new_is;
    logic        new_mark;
    logic        variable_length_mode;
    logic [31:0] target;
    logic [31:0] data;
  } pts_retire_s;

  // One trace message handed to the message queue.
  typedef struct packed {
    logic [5:0]  tcode;
    logic [3:0]  src;
    logic        ispace;
    logic [3:0]  code;
    logic [7:0]  sequential_instr_count;
    logic [31:0] addr;
    logic [31:0] data;
  } pts_msg_s;

endpackage : pts_pkg
`default_nettype wire

// [pts_trace.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: TLB write emits correlation with new entry.
// R2: History correlation message precedes the entry message.
// R3: Invalidate emits correlation with address and count.
// R4: Process-ID write emits correlation with space bit.
// R5: Space-bit change emits correlation with process ID.
// R6: Full queue drops all until drained, then error.
// R7: Branch address is XOR-compressed; sync sends full.
// R8: Reset, enable, low power, debug exit force sync.
// R9: Queue overrun forces next branch sync.
// R10: Every 255 non-sync messages forces sync; the code counts non-sync branch messages only.
// R11: Event-in pin assertion forces sync when permitted.
// R12: Count 255 queues resource-full and forces sync.
// R13: Branch at count 255 sends no resource-full.
// R14: Same-cycle messages ordered oldest instruction first.
// R15: Younger branch behind three messages is lost, error.
// R16: After loss, sync count includes the lost branch.
// R17: Variable-length mode switch forces sync.
// R18: Mark bit rising with mark enable forces sync.
// R19: Branch sync format: type, source, space, count, address.
// R20: History sync adds branch history field.
// R21: Reset clears state; first message is sync.
// R22: Tool enables trace by mode field or watchpoint.
// R23: Resource-full codes: counter 0/0xff, history 1/buffer.
// R24: History cleared when sent and on debug exit.
// R25: Sync triggers pend until a sync branch is queued.
module pts_trace
  import pts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire pts_retire_s retire,
  output logic             retire_ready,
  input  wire logic [1:0]  prior_msgs,
  input  wire logic        low_power,
  input  wire logic        debug_mode,
  input  wire logic        watch_program_trace_start,
  input  wire logic        event_in_n,
  input  wire logic        queue_full,
  input  wire logic        queue_empty,
  output pts_msg_s         msg,
  output logic             msg_valid
);

  pts_state_e        state_q, state_d;
  logic [31:0]       ctrl_q;
  logic              started_q, mark_q, is_q, vle_q, lowpwr_q, debug_q;
  logic [31:0]       pid_q, last_addr_q, hist_q, tlb_entry_q;
  logic [7:0]        sequential_instr_count_q, per_cnt_q;
  logic [PEND_W-1:0] pend_q, pend_d, pend_set;
  logic [3:0]        drop_mask_q;
  logic              evti_m_q, evti_s_q, evti_d_q;
  logic              trace_en_q;
  logic [31:0]       rdata_q;
  pts_msg_s          msg_q, msg_d;
  logic              msg_valid_q;

  // Control decode. A watchpoint start latches until software disables trace.
  wire       trace_en  = ctrl_q[CTRL_EN_BIT] | started_q;  // R22
  wire       hist_on   = ctrl_q[CTRL_HIST_BIT];
  wire       mark_en   = ctrl_q[CTRL_MARK_BIT];
  wire       pt_active = trace_en & (~mark_en | mark_q);
  wire [3:0] src_id    = ctrl_q[CTRL_SRC_LSB +: 4];

  // Instruction acceptance and per-instruction decode.
  wire       ev        = retire.valid & retire_ready & pt_active;
  wire [7:0] sequential_instr_count_inc  = 8'(sequential_instr_count_q + 8'h01);
  wire       cnt_wrap  = (sequential_instr_count_inc == SEQUENTIAL_INSTR_COUNT_MAX);
  wire       dir_hist  = retire.branch & ~retire.indirect & hist_on;
  wire       br_msg    = retire.branch & (retire.indirect | (~hist_on & retire.taken));
  wire       is_change = retire.msr_write & (retire.new_is != is_q);
  wire       br_lost   = br_msg & retire.younger & (prior_msgs == PRIO_FULL);  // R15
  // An enable that rises in the cycle of a branch must already make it sync.
  wire       en_rise   = trace_en & ~trace_en_q;                            // R8
  wire       sync_now  = (|pend_q) | en_rise;                               // R25
  wire       evti_edge = evti_d_q & ~evti_s_q;

  // Message kind of the accepted instruction. Correlation events win over
  // branch, and a messaged branch beats the resource-full at count 255.
  wire pts_kind_e ev_kind =
      !ev                        ? K_NONE :
      retire.tlb_write           ? K_TLB_HIST :   // R2
      retire.tlb_inval           ? K_INVAL :      // R3
      retire.pid_write           ? K_PID :        // R4 R14
      is_change                  ? K_ISPACE :     // R5
      br_lost                    ? K_ERR_COLL :   // R15
      br_msg                     ? K_BRANCH :     // R13
      (dir_hist && hist_q[31])   ? K_RES_HIST :
      cnt_wrap                   ? K_RES_SEQUENTIAL_INSTR_COUNT :   // R12
                                   K_NONE;

  // Kind actually presented this cycle, given the sequencer state.
  wire pts_kind_e kind =
      (state_q == ST_TLB2) ? K_TLB_ENTRY :                         // R1
      (state_q == ST_DROP) ? (queue_empty ? K_ERR_OVR : K_NONE) :  // R6
                             ev_kind;

  // While dropping, any would-be message only marks its type.
  wire attempt  = (ev_kind != K_NONE);
  wire dropping = (state_q == ST_DROP) & ~queue_empty & attempt;
  wire emit_try = (kind != K_NONE);
  wire overflow = emit_try & queue_full & (state_q != ST_DROP);    // R6
  wire emit_ok  = emit_try & ~overflow;

  wire [3:0] kind_mask =
      (ev_kind == K_BRANCH)                            ? 4'h1 :
      (ev_kind == K_RES_SEQUENTIAL_INSTR_COUNT || ev_kind == K_RES_HIST) ? 4'h4 :
      (ev_kind == K_ERR_COLL)                          ? 4'h8 :
                                                         4'h2;

  wire sync_branch = (kind == K_BRANCH) & sync_now;

  // The instruction port stalls while the second TLB message or the
  // overrun error goes out, so no retired instruction is ever skipped.
  assign retire_ready = (state_q == ST_IDLE) | ((state_q == ST_DROP) & ~queue_empty);

  // Branch message type selection.
  function automatic logic [5:0] br_tcode(input logic ind, input logic hist,
                                          input logic sync);
    if (ind && hist) begin
      br_tcode = sync ? TC_HIST_SYNC : TC_HIST;          // R20
    end else if (ind) begin
      br_tcode = sync ? TC_INDIR_SYNC : TC_INDIRECT;     // R19
    end else begin
      br_tcode = sync ? TC_DIRECT_SYNC : TC_DIRECT;      // R19
    end
  endfunction : br_tcode

  // Build the message for the current kind.
  always_comb begin
    msg_d        = '0;
    msg_d.src    = src_id;
    msg_d.ispace = is_q;
    msg_d.sequential_instr_count   = sequential_instr_count_inc;
    msg_d.data   = hist_q;
    case (kind)
      K_TLB_HIST: begin
        msg_d.tcode = TC_CORR;
        msg_d.code  = EV_TLB_WRITE;                      // R2
      end
      K_TLB_ENTRY: begin
        msg_d.tcode = TC_CORR;
        msg_d.code  = EV_TLB_WRITE;                      // R1
        msg_d.sequential_instr_count  = 8'h00;
        msg_d.addr  = tlb_entry_q;
        msg_d.data  = HIST_RESET;
      end
      K_INVAL: begin
        msg_d.tcode = TC_CORR;
        msg_d.code  = EV_TLB_INVAL;                      // R3
        msg_d.addr  = retire.data;
      end
      K_PID: begin
        msg_d.tcode = TC_CORR;
        msg_d.code  = EV_PID;                            // R4
        msg_d.addr  = retire.data;
      end
      K_ISPACE: begin
        msg_d.tcode  = TC_CORR;
        msg_d.code   = EV_ISPACE;                        // R5
        msg_d.ispace = retire.new_is;
        msg_d.addr   = pid_q;
      end
      K_BRANCH: begin
        msg_d.tcode = br_tcode(retire.indirect, hist_on, sync_now);
        msg_d.addr  = sync_now ? retire.target : (retire.target ^ last_addr_q);  // R7
        msg_d.data  = (retire.indirect && hist_on) ? hist_q : 32'h0000_0000;
      end
      K_RES_SEQUENTIAL_INSTR_COUNT: begin
        msg_d.tcode = TC_RES_FULL;
        msg_d.code  = RC_SEQUENTIAL_INSTR_COUNT;                           // R23
        msg_d.data  = {24'h00_0000, RDATA_SEQUENTIAL_INSTR_COUNT};
      end
      K_RES_HIST: begin
        msg_d.tcode = TC_RES_FULL;
        msg_d.code  = RC_HIST;                           // R23
      end
      K_ERR_COLL: begin
        msg_d.tcode = TC_ERROR;
        msg_d.code  = ERR_COLLIDE;                       // R15
        msg_d.data  = {28'h000_0000, 4'h1};
      end
      K_ERR_OVR: begin
        msg_d.tcode = TC_ERROR;
        msg_d.code  = ERR_OVERRUN;                       // R6
        msg_d.data  = {28'h000_0000, drop_mask_q};
      end
      default: begin
        msg_d.tcode = 6'h00;
      end
    endcase
  end

  // Sequencer: the TLB pair, and the drain wait after an overrun.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (overflow) begin
          state_d = ST_DROP;                             // R6
        end else if (kind == K_TLB_HIST) begin
          state_d = ST_TLB2;                             // R2
        end
      end
      ST_TLB2: begin
        state_d = overflow ? ST_DROP : ST_IDLE;
      end
      ST_DROP: begin
        if (queue_empty) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Synchronisation triggers. A trigger in the clearing cycle survives.
  always_comb begin
    pend_set             = '0;
    pend_set[P_RESET]    = en_rise;                                     // R8
    pend_set[P_LOWPWR]   = lowpwr_q & ~low_power;                       // R8
    pend_set[P_DEBUG]    = debug_q & ~debug_mode;                       // R8
    pend_set[P_OVERRUN]  = (kind == K_ERR_OVR);                         // R9
    pend_set[P_PERIODIC] = emit_ok & (kind == K_BRANCH) & ~sync_now
                           & (8'(per_cnt_q + 8'h01) == PERIOD_MAX);     // R10
    pend_set[P_EVTI]     = evti_edge & ctrl_q[CTRL_EVTI_BIT] & pt_active;  // R11
    pend_set[P_SEQUENTIAL_INSTR_COUNT]     = (ev_kind == K_RES_SEQUENTIAL_INSTR_COUNT)
                           | ((ev_kind == K_BRANCH) & cnt_wrap);        // R12 R13
    pend_set[P_COLLIDE]  = (ev_kind == K_ERR_COLL);                     // R16
    pend_set[P_VLE]      = ev & (retire.variable_length_mode != vle_q);                  // R17
    pend_set[P_MARK]     = mark_en & retire.valid & retire_ready
                           & retire.msr_write & retire.new_mark & ~mark_q;  // R18
    pend_d = ((sync_branch & emit_ok) ? '0 : pend_q) | pend_set;        // R25
  end

  // Core state. All of it returns to reset values, so the first branch after
  // reset already sees the reset flag pending.
  always_ff @(posedge clk) begin
    if (!reset_n) begin                                                 // R21
      state_q     <= ST_IDLE;
      pend_q      <= PEND_RESET;
      drop_mask_q <= 4'h0;
      trace_en_q  <= 1'b0;
      lowpwr_q    <= 1'b0;
      debug_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      pend_q     <= pend_d;
      trace_en_q <= trace_en;
      lowpwr_q   <= low_power;
      debug_q    <= debug_mode;
      if (kind == K_ERR_OVR) begin
        drop_mask_q <= 4'h0;
      end else if (overflow) begin
        drop_mask_q <= (kind == K_TLB_ENTRY) ? 4'h2 : kind_mask;
      end else if (dropping) begin
        drop_mask_q <= drop_mask_q | kind_mask;
      end
    end
  end

  // Instruction counter and compression base. A lost branch keeps counting, as do
  // history-full and message-free instructions, so the later sync count covers that branch too.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sequential_instr_count_q      <= 8'h00;
      last_addr_q <= 32'h0000_0000;
    end else if (ev) begin
      case (ev_kind)
        K_ERR_COLL, K_RES_HIST, K_NONE: sequential_instr_count_q <= sequential_instr_count_inc;             // R16
        default:                       sequential_instr_count_q <= 8'h00;                // R12
      endcase
      if (ev_kind == K_BRANCH) begin
        last_addr_q <= retire.target;                                   // R7
      end
    end
  end

  // Branch history: shifts on direct branches in history mode and restarts
  // whenever it has been sent, or when debug mode ends.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hist_q <= HIST_RESET;
    end else if (debug_q && !debug_mode) begin
      hist_q <= HIST_RESET;                                             // R24
    end else if (ev_kind == K_RES_HIST) begin
      hist_q <= {30'h0, 1'b1, retire.taken};                            // R24
    end else if (ev && ev_kind != K_NONE && ev_kind != K_ERR_COLL
                 && ev_kind != K_RES_SEQUENTIAL_INSTR_COUNT
                 && (ev_kind != K_BRANCH || retire.indirect)) begin
      hist_q <= HIST_RESET;                                             // R24
    end else if (ev && dir_hist) begin
      hist_q <= {hist_q[30:0], retire.taken};
    end
  end

  // Periodic counter of queued non-sync branch messages.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      per_cnt_q <= 8'h00;
    end else if (pend_set[P_PERIODIC] || (emit_ok && sync_branch)) begin
      per_cnt_q <= 8'h00;                                               // R10
    end else if (emit_ok && kind == K_BRANCH && !sync_now) begin
      per_cnt_q <= 8'(per_cnt_q + 8'h01);
    end
  end

  // Architectural shadows: process ID, space bit, mark bit, mode, TLB entry.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pid_q       <= 32'h0000_0000;
      is_q        <= 1'b0;
      mark_q      <= 1'b0;
      vle_q       <= 1'b0;
      tlb_entry_q <= 32'h0000_0000;
    end else if (retire.valid && retire_ready) begin
      pid_q       <= retire.pid_write ? retire.data : pid_q;
      is_q        <= retire.msr_write ? retire.new_is : is_q;
      mark_q      <= retire.msr_write ? retire.new_mark : mark_q;
      vle_q       <= retire.variable_length_mode;
      tlb_entry_q <= retire.tlb_write ? retire.data : tlb_entry_q;
    end
  end

  // Event-in pin synchroniser; the edge detect compares the second and third stages.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evti_m_q <= 1'b1;
      evti_s_q <= 1'b1;
      evti_d_q <= 1'b1;
    end else begin
      evti_m_q <= event_in_n;
      evti_s_q <= evti_m_q;
      evti_d_q <= evti_s_q;
    end
  end

  // Register port. Read data stand only in the cycle after the strobe.
  wire [31:0] stat_word = {15'h0, is_q, drop_mask_q, state_q, pend_q};
  wire [31:0] cnt_word  = {16'h0000, per_cnt_q, sequential_instr_count_q};
  wire [31:0] rd_mux    = (reg_addr == PTS_CTRL_OFS) ? ctrl_q :
                          (reg_addr == PTS_STAT_OFS) ? stat_word :
                          (reg_addr == PTS_CNT_OFS)  ? cnt_word : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q    <= CTRL_RESET;
      started_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      if (reg_wr && reg_addr == PTS_CTRL_OFS) begin
        ctrl_q <= reg_wdata;
      end
      if (watch_program_trace_start) begin
        started_q <= 1'b1;                                              // R22
      end else if (reg_wr && reg_addr == PTS_CTRL_OFS && !reg_wdata[CTRL_EN_BIT]) begin
        started_q <= 1'b0;
      end
    end
  end

  // Output stage toward the message queue.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      msg_q       <= '0;
      msg_valid_q <= 1'b0;
    end else begin
      msg_q       <= msg_d;
      msg_valid_q <= emit_ok;                                           // R6
    end
  end

  assign msg       = msg_q;
  assign msg_valid = msg_valid_q;
  assign reg_rdata = rdata_q;

  // Checks on the message stream.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_tlb_pair;
    (kind == K_TLB_HIST) && emit_ok |=> (kind == K_TLB_ENTRY) ##1
      (!msg_valid || (msg.code == EV_TLB_WRITE && msg.addr == $past(tlb_entry_q)));
  endproperty
  a_tlb_pair: assert property (p_tlb_pair) else $error("TLB entry message missing"); // R1

  property p_drop_silent;
    (state_q == ST_DROP) && !queue_empty |=> !msg_valid;
  endproperty
  a_drop_silent: assert property (p_drop_silent) else $error("Message sent while dropping"); // R6

  property p_err_after_drain;
    (state_q == ST_DROP) && queue_empty |=> msg_valid && msg.tcode == TC_ERROR
      ##1 pend_q[P_OVERRUN] || msg_valid;
  endproperty
  a_err_after_drain: assert property (p_err_after_drain) else $error("No overrun error"); // R9

  property p_sync_full_addr;
    sync_branch && emit_ok |=> msg_valid && msg.addr == $past(retire.target);
  endproperty
  a_sync_full_addr: assert property (p_sync_full_addr) else $error("Sync address compressed"); // R7

  property p_compress;
    (kind == K_BRANCH) && emit_ok && !sync_now |=>
      msg.addr == ($past(retire.target) ^ $past(last_addr_q));
  endproperty
  a_compress: assert property (p_compress) else $error("Bad compressed address"); // R7

  property p_sequential_instr_count_res;
    msg_valid && msg.tcode == TC_RES_FULL && msg.code == RC_SEQUENTIAL_INSTR_COUNT |->
      msg.data == 32'h0000_00ff ##1 (pend_q[P_SEQUENTIAL_INSTR_COUNT] || $past(sync_branch));
  endproperty
  a_sequential_instr_count_res: assert property (p_sequential_instr_count_res) else $error("Resource full data wrong"); // R23

  property p_collision;
    ev && br_lost && !queue_full |=> msg_valid && msg.tcode == TC_ERROR && pend_q[P_COLLIDE];
  endproperty
  a_collision: assert property (p_collision) else $error("Lost branch not reported"); // R15

  property p_periodic;
    pend_set[P_PERIODIC] |=> per_cnt_q == 8'h00 && pend_q[P_PERIODIC];
  endproperty
  a_periodic: assert property (p_periodic) else $error("Periodic sync not raised"); // R10

  property p_sync_clears;
    sync_branch && emit_ok && pend_set == '0 |=> pend_q == '0;
  endproperty
  a_sync_clears: assert property (p_sync_clears) else $error("Pending flags not cleared"); // R25

endmodule : pts_trace
`default_nettype wire

// [pts_queue_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-side message queue; hold stalls the drain so a test can force an overrun.
module pts_queue_model #(
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic push,
  input  wire logic hold,
  output logic      full,
  output logic      empty
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // A push into a full queue is lost, so the block must drop and later report it.
  assign cnt_d = cnt_q + 4'(push && !full) - 4'(!hold && !empty);
  assign full  = (cnt_q == 4'(DEPTH));
  assign empty = (cnt_q == 4'h0);
  // Occupancy counter.
  always_ff @(posedge clk) begin
    if (!reset_n) cnt_q <= 4'h0;
    else cnt_q <= cnt_d;
  end
endmodule : pts_queue_model
`default_nettype wire

// [pts_trace_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pts_trace_tb import pts_pkg::*;;
  logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hold = 1'b0;
  logic        low_power = 1'b0, debug_mode = 1'b0, event_in_n = 1'b1, wpt_start = 1'b0;
  logic [1:0]  prior = 2'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        retire_ready, queue_full, queue_empty, msg_valid;
  pts_retire_s retire = '0;
  pts_msg_s    msg, m;
  pts_msg_s    got_q[$];
  int          n_fail = 0, n_compared = 0;
  always #5 clk = ~clk;
  pts_trace u_pts_trace (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .retire(retire), .retire_ready(retire_ready), .prior_msgs(prior),
    .low_power(low_power), .debug_mode(debug_mode), .watch_program_trace_start(wpt_start),
    .event_in_n(event_in_n), .queue_full(queue_full), .queue_empty(queue_empty),
    .msg(msg), .msg_valid(msg_valid));
  pts_queue_model u_pts_queue_model (.clk(clk), .reset_n(reset_n), .push(msg_valid),
    .hold(hold), .full(queue_full), .empty(queue_empty));
  // Every queued message is captured in order for the checks below.
  always @(posedge clk) if (msg_valid === 1'b1) got_q.push_back(msg);
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // Kind 0 indirect branch, 1 table write, 2 invalidate, 3 process-id write.
  task automatic ret(input logic [1:0] k, input logic [31:0] v);
    pts_retire_s r;
    r = '0; r.valid = 1'b1; r.branch = (k == 2'd0); r.indirect = (k == 2'd0);
    r.taken = (k == 2'd0); r.tlb_write = (k == 2'd1); r.tlb_inval = (k == 2'd2);
    r.pid_write = (k == 2'd3); r.target = v; r.data = v; r.younger = (prior != 2'h0);
    retire <= r;
    do @(posedge clk); while (retire_ready !== 1'b1);
    retire <= '0;
    repeat (3) @(posedge clk);
  endtask : ret
  // Bounded wait for the next captured message, then type compare, and code compare for correlation and error types only.
  task automatic take(input logic [5:0] tc, input logic [3:0] cd);
    int i;
    i = 0;
    while (got_q.size() == 0 && i < 20) begin
      @(posedge clk); i++;
    end
    if (got_q.size() == 0) begin
      n_fail++;
      $display("BAD msg expected %h seen none", tc);
    end else begin
      m = got_q.pop_front();
      chk("tcode", 32'(tc), 32'(m.tcode));
      if (tc == TC_CORR || tc == TC_ERROR) chk("code", 32'(cd), 32'(m.code));
    end
  endtask : take
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(PTS_CTRL_OFS, CTRL_RESET);
    wr(PTS_CTRL_OFS, 32'h0000_0055);
    rd(PTS_CTRL_OFS, 32'h0000_0055);
    rd(8'h3c, 32'h0);
    ret(2'd0, 32'h0000_1000); take(TC_INDIR_SYNC, 4'h0);
    chk("addr", 32'h0000_1000, m.addr); chk("src", 32'h5, 32'(m.src));
    ret(2'd0, 32'h0000_1234); take(TC_INDIRECT, 4'h0);
    chk("addr", 32'h0000_0234, m.addr);
    ret(2'd1, 32'h0000_00aa); take(TC_CORR, EV_TLB_WRITE);
    take(TC_CORR, EV_TLB_WRITE); chk("addr", 32'h0000_00aa, m.addr);
    ret(2'd2, 32'h0000_5550); take(TC_CORR, EV_TLB_INVAL);
    chk("addr", 32'h0000_5550, m.addr);
    ret(2'd3, 32'h0000_0007); take(TC_CORR, EV_PID);
    chk("addr", 32'h0000_0007, m.addr);
    // Stall the drain so the fifth and sixth branches meet a full queue.
    hold <= 1'b1;
    for (int i = 0; i < 6; i++) ret(2'd0, 32'h0000_2000 + 32'(i));
    got_q.delete();
    hold <= 1'b0;
    take(TC_ERROR, ERR_OVERRUN); chk("drop", 32'h1, 32'(m.data[DROP_BRANCH]));
    ret(2'd0, 32'h0000_3000); take(TC_INDIR_SYNC, 4'h0);
    chk("addr", 32'h0000_3000, m.addr);
    // Low-power exit, debug exit and event-in each force the next sync.
    for (int k = 0; k < 3; k++) begin
      ret(2'd0, 32'h0000_4000); take(TC_INDIRECT, 4'h0);
      low_power <= (k == 0); debug_mode <= (k == 1); event_in_n <= (k != 2);
      repeat (4) @(posedge clk);
      low_power <= 1'b0; debug_mode <= 1'b0; event_in_n <= 1'b1;
      repeat (4) @(posedge clk);
      ret(2'd0, 32'h0000_5000); take(TC_INDIR_SYNC, 4'h0);
    end
    // A younger branch behind three messages is lost; the next sync counts it.
    prior <= 2'h3; @(posedge clk);
    ret(2'd0, 32'h0000_6000); prior <= 2'h0; take(TC_ERROR, ERR_COLLIDE);
    ret(2'd0, 32'h0000_6100); take(TC_INDIR_SYNC, 4'h0);
    chk("sequential_instr_count", 32'h2, 32'(m.sequential_instr_count));
    // The 255th non-sync branch message makes the following one sync.
    for (int i = 0; i < 255; i++) begin
      ret(2'd0, 32'h0000_8000 + 32'(i)); take(TC_INDIRECT, 4'h0);
    end
    ret(2'd0, 32'h0000_9000); take(TC_INDIR_SYNC, 4'h0);
    // Trace off by software, then back on by a watchpoint start pulse.
    wr(PTS_CTRL_OFS, 32'h0000_0054);
    wpt_start <= 1'b1; @(posedge clk); wpt_start <= 1'b0;
    ret(2'd0, 32'h0000_7000); take(TC_INDIR_SYNC, 4'h0);
    close_out();
  end
  // Watchdog well beyond the thousand-odd cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule : pts_trace_tb
`default_nettype wire
